// *** hw/vmon_pkg.sv ***
package vmon_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and conversion timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TIME_NS  = 711000;
  localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Converter and averaging
  localparam int unsigned CODE_W    = 10;
  localparam int unsigned READ_W    = 8;
  localparam int unsigned AVG_COUNT = 16;
  localparam int unsigned AVG_SHIFT = 4;
  localparam int unsigned ACC_W     = CODE_W + AVG_SHIFT;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_RAIL_2V5_READING    = 8'h20;
  localparam logic [7:0] ADDR_SUPPLY_RAIL_READING = 8'h22;
  localparam logic [7:0] ADDR_CONFIG_ONE          = 8'h40;
  localparam logic [7:0] ADDR_RAIL_2V5_LOW_LIMIT  = 8'h44;
  localparam logic [7:0] ADDR_RAIL_2V5_HIGH_LIMIT = 8'h45;
  localparam logic [7:0] ADDR_SUPPLY_LOW_LIMIT    = 8'h48;
  localparam logic [7:0] ADDR_SUPPLY_HIGH_LIMIT   = 8'h49;
  localparam logic [7:0] ADDR_CONFIG_TWO          = 8'h73;
  localparam logic [7:0] ADDR_LIMIT_STATUS        = 8'h7e;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int unsigned SUPPLY_5V_BIT   = 7;
  localparam int unsigned AVG_OFF_BIT     = 4;
  localparam int unsigned STAT_2V5_BIT    = 0;
  localparam int unsigned STAT_SUPPLY_BIT = 1;
  localparam logic [7:0] READING_RST     = 8'h00;
  localparam logic [7:0] LOW_LIMIT_RST   = 8'h00;
  localparam logic [7:0] HIGH_LIMIT_RST  = 8'hff;
  localparam logic [7:0] CONFIG_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Channel codes and sequencer states
  localparam logic CH_2V5    = 1'b0;
  localparam logic CH_SUPPLY = 1'b1;

  typedef enum logic [0:0] {
    ST_START = 1'b0,
    ST_WAIT  = 1'b1
  } seq_state_t;

endpackage

// *** hw/voltage_monitor_adc_control.sv ***
`timescale 1ns/1ns
module voltage_monitor_adc_control
  import vmon_pkg::*;
#(
  parameter int unsigned CONV_CYCLES_P = CONV_CYCLES
)(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   adc_start,
  output logic                   adc_chan,
  output logic                   supply_5v_scale,
  input  wire logic              adc_done,
  input  wire logic [CODE_W-1:0] adc_code,
  input  wire logic              adc_over,
  output logic                   alert_out,
  output logic                   alert_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]        rd_2v5_q;
  logic [7:0]        rd_sup_q;
  logic [7:0]        lo_2v5_q;
  logic [7:0]        hi_2v5_q;
  logic [7:0]        lo_sup_q;
  logic [7:0]        hi_sup_q;
  logic [7:0]        cfg1_q;
  logic [7:0]        cfg2_q;
  logic [1:0]        stat_q;
  logic [1:0]        viol_q;
  logic [7:0]        rdata_d;
  logic [7:0]        reg_rdata_q;
  seq_state_t        state_q;
  logic [31:0]       pace_q;
  logic              chan_q;
  logic [AVG_SHIFT-1:0] nsamp_q;
  logic [ACC_W-1:0]  acc_q;
  logic              meas_q;
  logic              meas_chan_q;
  logic [CODE_W-1:0] meas_code_q;
  logic [CODE_W-1:0] sample;
  logic [ACC_W-1:0]  acc_sum;
  logic              avg_off;
  logic              last_samp;
  logic [7:0]        meas_msb;
  logic [1:0]        viol_now;
  logic              stat_rd;

  assign avg_off   = cfg2_q[AVG_OFF_BIT];
  assign sample    = adc_over ? CODE_MAX : adc_code;
  assign acc_sum   = acc_q + ACC_W'(sample);
  assign last_samp = avg_off || (nsamp_q == AVG_SHIFT'(AVG_COUNT - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  assign adc_start       = (state_q == ST_START);
  assign adc_chan        = chan_q;
  assign supply_5v_scale = cfg1_q[SUPPLY_5V_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q <= ST_START;
      pace_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_START:
        begin
          pace_q  <= CONV_CYCLES_P - 1;
          state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (pace_q != '0)
          begin
            pace_q <= pace_q - 1;
          end
          else
          begin
            state_q <= ST_START;
          end
        end
        default:
        begin
          state_q <= ST_START;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulation and channel turn
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      chan_q      <= CH_2V5;
      nsamp_q     <= '0;
      acc_q       <= '0;
      meas_q      <= 1'b0;
      meas_chan_q <= CH_2V5;
      meas_code_q <= '0;
    end
    else
    begin
      meas_q <= 1'b0;
      if (adc_done)
      begin
        if (last_samp)
        begin
          meas_q      <= 1'b1;
          meas_chan_q <= chan_q;
          meas_code_q <= avg_off ? sample : CODE_W'(acc_sum >> AVG_SHIFT);
          acc_q       <= '0;
          nsamp_q     <= '0;
          chan_q      <= ~chan_q;
        end
        else
        begin
          acc_q   <= acc_sum;
          nsamp_q <= nsamp_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reading registers and limit comparison
  assign meas_msb = meas_code_q[CODE_W-1 -: READ_W];
  assign stat_rd  = reg_re && (reg_addr == ADDR_LIMIT_STATUS);

  always_comb
  begin
    viol_now = viol_q;
    if (meas_q && meas_chan_q == CH_2V5)
    begin
      viol_now[STAT_2V5_BIT] = (meas_msb > hi_2v5_q) || (meas_msb < lo_2v5_q);
    end
    if (meas_q && meas_chan_q == CH_SUPPLY)
    begin
      viol_now[STAT_SUPPLY_BIT] = (meas_msb > hi_sup_q) || (meas_msb < lo_sup_q);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rd_2v5_q <= READING_RST;
      rd_sup_q <= READING_RST;
      viol_q   <= '0;
    end
    else
    begin
      viol_q <= viol_now;
      if (meas_q && meas_chan_q == CH_2V5)
      begin
        rd_2v5_q <= meas_msb;
      end
      if (meas_q && meas_chan_q == CH_SUPPLY)
      begin
        rd_sup_q <= meas_msb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status bits and alert
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q <= (stat_q & ~({2{stat_rd}} & ~viol_now)) | viol_now;
    end
  end

  assign alert_out = 1'b0;
  assign alert_oe  = |stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lo_2v5_q <= LOW_LIMIT_RST;
      hi_2v5_q <= HIGH_LIMIT_RST;
      lo_sup_q <= LOW_LIMIT_RST;
      hi_sup_q <= HIGH_LIMIT_RST;
      cfg1_q   <= CONFIG_RST;
      cfg2_q   <= CONFIG_RST;
    end
    else if (reg_we)
    begin
      case (reg_addr)
        ADDR_RAIL_2V5_LOW_LIMIT:  lo_2v5_q <= reg_wdata;
        ADDR_RAIL_2V5_HIGH_LIMIT: hi_2v5_q <= reg_wdata;
        ADDR_SUPPLY_LOW_LIMIT:    lo_sup_q <= reg_wdata;
        ADDR_SUPPLY_HIGH_LIMIT:   hi_sup_q <= reg_wdata;
        ADDR_CONFIG_ONE:          cfg1_q   <= reg_wdata;
        ADDR_CONFIG_TWO:          cfg2_q   <= reg_wdata;
        default:                  cfg1_q   <= cfg1_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  always_comb
  begin
    case (reg_addr)
      ADDR_RAIL_2V5_READING:    rdata_d = rd_2v5_q;
      ADDR_SUPPLY_RAIL_READING: rdata_d = rd_sup_q;
      ADDR_CONFIG_ONE:          rdata_d = cfg1_q;
      ADDR_RAIL_2V5_LOW_LIMIT:  rdata_d = lo_2v5_q;
      ADDR_RAIL_2V5_HIGH_LIMIT: rdata_d = hi_2v5_q;
      ADDR_SUPPLY_LOW_LIMIT:    rdata_d = lo_sup_q;
      ADDR_SUPPLY_HIGH_LIMIT:   rdata_d = hi_sup_q;
      ADDR_CONFIG_TWO:          rdata_d = cfg2_q;
      ADDR_LIMIT_STATUS:        rdata_d = {6'h00, stat_q};
      default:                  rdata_d = UNMAPPED_RDATA;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rdata_q <= UNMAPPED_RDATA;
    end
    else if (reg_re)
    begin
      reg_rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule

// *** testbench/vmon_asserts.sv ***
`timescale 1ns/1ns
module vmon_checker
  import vmon_pkg::*;
#(
  parameter int unsigned CONV_CYCLES_P = CONV_CYCLES
)(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_we,
  input wire logic       reg_re,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       adc_start,
  input wire logic       adc_chan,
  input wire logic       supply_5v_scale,
  input wire logic       adc_done,
  input wire logic       alert_out,
  input wire logic       alert_oe
);
  localparam int PER = CONV_CYCLES_P + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_start_period: assert property (adc_start |-> ##PER adc_start)
    else $error("start spacing wrong");
  a_start_reset: assert property ($fell(srst) |-> adc_start)
    else $error("no start after reset");
  a_chan_hold: assert property (!srst && !adc_done |=> $stable(adc_chan))
    else $error("channel moved mid measurement");
  a_alert_level: assert property (!alert_out)
    else $error("alert drives high");
  a_scale_cfg: assert property (!srst && reg_we && reg_addr == ADDR_CONFIG_ONE
    |=> supply_5v_scale == $past(reg_wdata[SUPPLY_5V_BIT])) else $error("scale bit wrong");
  a_limit_back: assert property (!srst && reg_we && reg_addr == 8'h45 ##2
    reg_re && reg_addr == 8'h45 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("limit readback wrong");
  a_alert_cause: assert property ($rose(alert_oe)
    |-> $past(adc_done) || $past(adc_done, 2))
    else $error("alert without measurement");
  a_alert_clear: assert property ($fell(alert_oe) && !$past(srst) |-> $past(reg_re))
    else $error("alert dropped without read");
endmodule
bind voltage_monitor_adc_control vmon_checker #(.CONV_CYCLES_P(CONV_CYCLES_P)) i_chk (
  .ref_clk, .srst, .reg_addr, .reg_we, .reg_re, .reg_wdata, .reg_rdata, .adc_start,
  .adc_chan, .supply_5v_scale, .adc_done, .alert_out, .alert_oe);

// *** testbench/rail_model.sv ***
`timescale 1ns/1ns
module rail_model
  import vmon_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       adc_start,
  input  wire logic       adc_chan,
  input  wire logic [9:0] level_2v5,
  input  wire logic [9:0] level_sup,
  input  wire logic [3:0] lag,
  output logic            adc_done = 1'b0,
  output logic      [9:0] adc_code = 10'h000,
  output logic            adc_over = 1'b0
);
  logic [9:0] lvl;
  int         left = -1;
  // One answer per start; code lines churn outside the done pulse
  always @(posedge ref_clk)
  begin
    adc_done <= 1'b0;
    adc_code <= ~adc_code;
    adc_over <= ~adc_over;
    if (adc_start)
      left <= lag;
    else if (left > 0)
      left <= left - 1;
    else if (left == 0)
    begin
      left <= -1;
      lvl = adc_chan ? level_sup : level_2v5;
      adc_done <= 1'b1;
      adc_code <= (lvl == CODE_MAX) ? ~adc_code : lvl;
      adc_over <= (lvl == CODE_MAX);
    end
  end
endmodule

// *** testbench/voltage_monitor_adc_control_test.sv ***
`timescale 1ns/1ns
module voltage_monitor_adc_control_test
  import vmon_pkg::*;
;
  logic       ref_clk, srst, reg_we, reg_re, adc_start, adc_chan, supply_5v_scale;
  logic       adc_done, adc_over, alert_out, alert_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, lo, hi;
  logic [9:0] adc_code, lv2, lvs;
  logic [3:0] lag;
  int         seed, n, bad_count, checks;
  logic [7:0] addrs [6] = '{8'h20, 8'h22, 8'h44, 8'h45, 8'h48, 8'h49};
  logic [7:0] rsts [6]  = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff};
  voltage_monitor_adc_control #(.CONV_CYCLES_P(20)) i_dut (.ref_clk, .srst, .reg_addr,
    .reg_we, .reg_re, .reg_wdata, .reg_rdata, .adc_start, .adc_chan, .supply_5v_scale,
    .adc_done, .adc_code, .adc_over, .alert_out, .alert_oe);
  rail_model i_rail (.ref_clk, .adc_start, .adc_chan, .level_2v5(lv2), .level_sup(lvs),
    .lag, .adc_done, .adc_code, .adc_over);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [1:0] viol(input logic [7:0] l, h);
    return {lvs[9:2] > h || lvs[9:2] < l, lv2[9:2] > h || lv2[9:2] < l};
  endfunction
  task automatic final_report();
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    {reg_addr, reg_wdata, reg_we} = {a, d, 1'b1};
    @(negedge ref_clk);
    reg_we = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    {reg_addr, reg_re} = {a, 1'b1};
    @(negedge ref_clk);
    reg_re = 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic flip();
    logic c;
    c = adc_chan;
    n = 0;
    while (adc_chan === c)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 2000)
      begin
        bad_count++;
        final_report();
      end
    end
  endtask
  initial
  begin
    {seed, bad_count, checks} = {32'h13b66, 64'h0};
    {ref_clk, srst, reg_we, reg_re, reg_addr, reg_wdata} = {4'h4, 16'h0000};
    {lv2, lvs, lag} = {10'h300, 10'h3ff, 4'hf};
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    foreach (addrs[i])
    begin
      rd(addrs[i]);
      chk(v, rsts[i]);
    end
    rd(8'h21);
    chk(v, UNMAPPED_RDATA);
    wr(8'h20, 8'h5a);
    rd(8'h20);
    chk(v, READING_RST);
    wr(8'h49, 8'hfe);
    repeat (2) flip();
    rd(8'h20);
    chk(v, 8'hc0);
    rd(8'h22);
    chk(v, 8'hff);
    rd(8'h7e);
    chk(v, 8'h02);
    chk({7'h0, alert_oe}, 8'h01);
    wr(8'h40, 8'h80);
    chk({7'h0, supply_5v_scale}, 8'h01);
    wr(8'h73, 8'h10);
    repeat (2) flip();
    chk(n[7:0], 8'h15);
    wr(8'h49, 8'hff);
    repeat (2) flip();
    rd(8'h7e);
    rd(8'h7e);
    chk(v, 8'h00);
    chk({7'h0, alert_oe}, 8'h00);
    repeat (6)
    begin
      {lv2, lvs, lo, hi, lag} = {$random(seed), $random(seed)};
      wr(8'h45, hi);
      rd(8'h45);
      chk(v, hi);
      wr(8'h44, lo);
      wr(8'h48, lo);
      wr(8'h49, hi);
      repeat (4) flip();
      rd(8'h7e);
      repeat (2) flip();
      rd(8'h7e);
      chk(v, {6'h00, viol(lo, hi)});
      chk({7'h0, alert_oe}, {7'h0, |viol(lo, hi)});
      rd(8'h20);
      chk(v, lv2[9:2]);
      rd(8'h22);
      chk(v, lvs[9:2]);
    end
    final_report();
  end
endmodule
